/* File: src/arsf_defines.svh */
// constants of the converter result and status flag block
`ifndef ARSF_DEFINES_SVH
`define ARSF_DEFINES_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define ARSF_NCH            4
`define ARSF_CW             2
`define ARSF_DW             10
`define ARSF_AW             8
`define ARSF_BW             32

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define ARSF_OFS_CTRL       8'h00
`define ARSF_OFS_MODE       8'h04
`define ARSF_OFS_CHEN       8'h08
`define ARSF_OFS_CHDIS      8'h0C
`define ARSF_OFS_CHSR       8'h10
`define ARSF_OFS_SR         8'h14
`define ARSF_OFS_LAST_RESULT_REG       8'h18
`define ARSF_OFS_CDR0       8'h20
`define ARSF_OFS_CDR_LAST   8'h2C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ARSF_CTRL_START     0
`define ARSF_MODE_SLEEP     0
`define ARSF_MODE_SLPACT    1
`define ARSF_SR_EOC_LSB     0
`define ARSF_SR_CHANNEL_OVERRUN_FLAG_LSB    8
`define ARSF_SR_DATA_READY_FLAG        16
`define ARSF_SR_GENERAL_OVERRUN_FLAG       17
`define ARSF_LAST_RESULT_REG_CH_LSB    12
`define ARSF_WORD_LSB       2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ARSF_RST_CHEN       4'h0
`define ARSF_RST_RESULT     10'h000
`define ARSF_RST_CHAN       2'h0
`define ARSF_RST_WORD       32'h0000_0000

`endif

/* File: src/arsf_pkg.sv */
// types of the converter result and status flag block
`include "arsf_defines.svh"

package arsf_pkg;
  typedef logic [`ARSF_DW-1:0]  arsf_result_t;
  typedef logic [`ARSF_CW-1:0]  arsf_chan_t;
  typedef logic [`ARSF_NCH-1:0] arsf_mask_t;

  typedef enum logic [2:0]
  {
    ARSF_SLP_AWAKE  = 3'b001,
    ARSF_SLP_PEND   = 3'b010,
    ARSF_SLP_ASLEEP = 3'b100
  } arsf_sleep_state_t;
endpackage

/* File: src/arsf_flag_cell.sv */
// sticky flag with set over clear priority
`timescale 1ns/100ps

module arsf_flag_cell
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  logic next_q;

  // an event in the clearing cycle must survive
  assign next_q = set | (q & ~clr);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= 1'b0;
    else
      q <= next_q;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_set_beats_clear:
    assert property (@(posedge sys_clk) disable iff (!arst_n) set && clr |=> q)
    else $error("flag lost an event set during a clear");
  a_clear_only_bare:
    assert property (@(posedge sys_clk) disable iff (!arst_n) clr && !set |=> !q)
    else $error("flag not cleared by a bare clear");

endmodule

/* File: src/arsf_sleep_ctl.sv */
// deferred sleep entry after the next finished conversion
`timescale 1ns/100ps

module arsf_sleep_ctl
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic sleep_req,
  input  wire logic conv_done,
  output logic      sleep_active
);

  arsf_pkg::arsf_sleep_state_t state;
  arsf_pkg::arsf_sleep_state_t next_state;
  logic                        next_sleep_active;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  // an idle converter never sleeps at once: wait for a finished conversion
  always_comb
  begin
    next_state = state;
    unique case (state)
      arsf_pkg::ARSF_SLP_AWAKE:
        if (sleep_req)
          next_state = arsf_pkg::ARSF_SLP_PEND;
      arsf_pkg::ARSF_SLP_PEND:
        if (!sleep_req)
          next_state = arsf_pkg::ARSF_SLP_AWAKE;
        else if (conv_done)
          next_state = arsf_pkg::ARSF_SLP_ASLEEP;
      arsf_pkg::ARSF_SLP_ASLEEP:
        if (!sleep_req)
          next_state = arsf_pkg::ARSF_SLP_AWAKE;
      default:
        next_state = arsf_pkg::ARSF_SLP_AWAKE;
    endcase
  end

  assign next_sleep_active = (next_state == arsf_pkg::ARSF_SLP_ASLEEP);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= arsf_pkg::ARSF_SLP_AWAKE;
      sleep_active <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      sleep_active <= next_sleep_active;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_armed_idle;
    sleep_req && !sleep_active && !conv_done ##1 sleep_req && !conv_done;
  endsequence

  sequence s_armed_done;
    sleep_req && state == arsf_pkg::ARSF_SLP_PEND ##0 conv_done;
  endsequence

  a_sleep_not_early:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_armed_idle |=> !sleep_active)
    else $error("sleep entered without a finished conversion");
  a_sleep_after_done:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_armed_done ##1 sleep_req |-> sleep_active)
    else $error("sleep not entered after the conversion finished");

endmodule

/* File: src/arsf_top.sv */
// converter result registers and status flags behind a plain register port
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "arsf_defines.svh"

module arsf_top
(
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic [`ARSF_AW-1:0]     addr,
  input  wire logic [`ARSF_BW-1:0]     wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [`ARSF_BW-1:0]     rd_data,
  input  wire logic                    core_eoc,
  input  wire arsf_pkg::arsf_chan_t    core_chan,
  input  wire arsf_pkg::arsf_result_t  core_data,
  output logic                         conv_start,
  output arsf_pkg::arsf_mask_t         chan_en,
  output logic                         conv_sleep
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic is_cdr(input logic [`ARSF_AW-1:0] a);
    return (a >= `ARSF_OFS_CDR0) && (a <= `ARSF_OFS_CDR_LAST)
           && (a[`ARSF_WORD_LSB-1:0] == 2'h0);
  endfunction

  function automatic arsf_pkg::arsf_chan_t cdr_index(input logic [`ARSF_AW-1:0] a);
    logic [`ARSF_AW-1:0] d;
    d = a - `ARSF_OFS_CDR0;
    return d[`ARSF_CW+`ARSF_WORD_LSB-1:`ARSF_WORD_LSB];
  endfunction

  logic                  wr_ctrl;
  logic                  wr_mode;
  logic                  wr_chen;
  logic                  wr_chdis;
  logic                  rd_sr;
  logic                  rd_last_result_reg;
  logic                  rd_cdr_any;
  arsf_pkg::arsf_chan_t  cdr_sel;
  arsf_pkg::arsf_mask_t  rd_cdr;

  assign wr_ctrl    = wr_en && (addr == `ARSF_OFS_CTRL);
  assign wr_mode    = wr_en && (addr == `ARSF_OFS_MODE);
  assign wr_chen    = wr_en && (addr == `ARSF_OFS_CHEN);
  assign wr_chdis   = wr_en && (addr == `ARSF_OFS_CHDIS);
  assign rd_sr      = rd_en && (addr == `ARSF_OFS_SR);
  assign rd_last_result_reg    = rd_en && (addr == `ARSF_OFS_LAST_RESULT_REG);
  assign rd_cdr_any = rd_en && is_cdr(addr);
  assign cdr_sel    = cdr_index(addr);
  assign rd_cdr     = rd_cdr_any ? arsf_pkg::arsf_mask_t'(1) << cdr_sel : '0;

  // ------------------------------------------------------------
  // control and channel enables
  // ------------------------------------------------------------
  logic                  sleep_req;
  logic                  next_sleep_req;
  logic                  next_conv_start;
  arsf_pkg::arsf_mask_t  en_now;
  arsf_pkg::arsf_mask_t  dis_now;
  arsf_pkg::arsf_mask_t  chan_en_eff;
  arsf_pkg::arsf_mask_t  next_chan_en;

  assign en_now          = wr_chen ? wr_data[`ARSF_NCH-1:0] : '0;
  assign dis_now         = wr_chdis ? wr_data[`ARSF_NCH-1:0] : '0;
  // a disable in the completion cycle already hides that channel
  assign chan_en_eff     = chan_en & ~dis_now;
  assign next_chan_en    = (chan_en | en_now) & ~dis_now;
  assign next_conv_start = wr_ctrl && wr_data[`ARSF_CTRL_START];
  assign next_sleep_req  = wr_mode ? wr_data[`ARSF_MODE_SLEEP] : sleep_req;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chan_en    <= `ARSF_RST_CHEN;
      conv_start <= 1'b0;
      sleep_req  <= 1'b0;
    end
    else
    begin
      chan_en    <= next_chan_en;
      conv_start <= next_conv_start;
      sleep_req  <= next_sleep_req;
    end
  end

  // ------------------------------------------------------------
  // result storage
  // ------------------------------------------------------------
  logic                   eoc_evt;
  arsf_pkg::arsf_result_t chan_result [`ARSF_NCH];
  arsf_pkg::arsf_result_t last_data;
  arsf_pkg::arsf_chan_t   last_ch;

  // completions of a disabled channel store nothing and raise no flag; sleep entry still counts them
  assign eoc_evt = core_eoc && chan_en_eff[core_chan];

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < `ARSF_NCH; i++)
        chan_result[i] <= `ARSF_RST_RESULT;
      last_data <= `ARSF_RST_RESULT;
      last_ch   <= `ARSF_RST_CHAN;
    end
    else if (eoc_evt)
    begin
      chan_result[core_chan] <= core_data;
      last_data              <= core_data;
      last_ch                <= core_chan;
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  arsf_pkg::arsf_mask_t eoc_q;
  arsf_pkg::arsf_mask_t eoc_set;
  arsf_pkg::arsf_mask_t eoc_clr;
  arsf_pkg::arsf_mask_t channel_overrun_flag_q;
  arsf_pkg::arsf_mask_t channel_overrun_flag_set;
  arsf_pkg::arsf_mask_t channel_overrun_flag_clr;
  logic                 data_ready_flag_q;
  logic                 general_overrun_flag_q;
  logic                 general_overrun_flag_set;

  genvar g;
  generate
    for (g = 0; g < `ARSF_NCH; g++)
    begin : g_chan
      assign eoc_set[g]  = eoc_evt && (core_chan == arsf_pkg::arsf_chan_t'(g));
      // last-result read clears the channel that owns the held result
      assign eoc_clr[g]  = rd_cdr[g]
                           || (rd_last_result_reg && (last_ch == arsf_pkg::arsf_chan_t'(g)));
      assign channel_overrun_flag_set[g] = eoc_set[g] && eoc_q[g];
      // uses the done flag before this edge, so a coinciding completion cannot block it
      assign channel_overrun_flag_clr[g] = rd_sr && !eoc_q[g];

      arsf_flag_cell u_eoc
      (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .set     (eoc_set[g]),
        .clr     (eoc_clr[g]),
        .q       (eoc_q[g])
      );

      arsf_flag_cell u_channel_overrun_flag
      (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .set     (channel_overrun_flag_set[g]),
        .clr     (channel_overrun_flag_clr[g]),
        .q       (channel_overrun_flag_q[g])
      );
    end
  endgenerate

  assign general_overrun_flag_set = eoc_evt && data_ready_flag_q;

  // only the last-result read clears data ready
  arsf_flag_cell u_data_ready_flag
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set     (eoc_evt),
    .clr     (rd_last_result_reg),
    .q       (data_ready_flag_q)
  );

  arsf_flag_cell u_general_overrun_flag
  (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .set     (general_overrun_flag_set),
    .clr     (rd_sr),
    .q       (general_overrun_flag_q)
  );

  // ------------------------------------------------------------
  // sleep
  // ------------------------------------------------------------
  arsf_sleep_ctl u_sleep
  (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .sleep_req    (sleep_req),
    .conv_done    (core_eoc),
    .sleep_active (conv_sleep)
  );

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [`ARSF_BW-1:0] mode_word;
  logic [`ARSF_BW-1:0] status_word;
  logic [`ARSF_BW-1:0] last_result_reg_word;
  logic [`ARSF_BW-1:0] cdr_word;
  logic [`ARSF_BW-1:0] rd_word;
  logic [`ARSF_BW-1:0] next_rd_data;

  assign mode_word   = (`ARSF_BW'(sleep_req) << `ARSF_MODE_SLEEP)
                     | (`ARSF_BW'(conv_sleep) << `ARSF_MODE_SLPACT);
  // a status read returns the flags as they stood before its own clears
  assign status_word = (`ARSF_BW'(eoc_q) << `ARSF_SR_EOC_LSB)
                     | (`ARSF_BW'(channel_overrun_flag_q) << `ARSF_SR_CHANNEL_OVERRUN_FLAG_LSB)
                     | (`ARSF_BW'(data_ready_flag_q) << `ARSF_SR_DATA_READY_FLAG)
                     | (`ARSF_BW'(general_overrun_flag_q) << `ARSF_SR_GENERAL_OVERRUN_FLAG);
  assign last_result_reg_word   = `ARSF_BW'(last_data) | (`ARSF_BW'(last_ch) << `ARSF_LAST_RESULT_REG_CH_LSB);
  assign cdr_word    = `ARSF_BW'(chan_result[cdr_sel]);

  assign rd_word = (addr == `ARSF_OFS_MODE) ? mode_word
                 : (addr == `ARSF_OFS_CHSR) ? `ARSF_BW'(chan_en)
                 : (addr == `ARSF_OFS_SR)   ? status_word
                 : (addr == `ARSF_OFS_LAST_RESULT_REG) ? last_result_reg_word
                 : is_cdr(addr)             ? cdr_word
                 : `ARSF_RST_WORD;

  assign next_rd_data = rd_en ? rd_word : `ARSF_RST_WORD;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= `ARSF_RST_WORD;
    else
      rd_data <= next_rd_data;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_store;
    eoc_evt ##1 (last_data == $past(core_data));
  endsequence

  a_data_ready_flag_last_result_reg_clear:
    assert property (rd_last_result_reg && !eoc_evt |=> !data_ready_flag_q)
    else $error("data ready kept after a last-result read");
  a_data_ready_flag_cdr_keep:
    assert property (rd_cdr_any && !eoc_evt |=> data_ready_flag_q == $past(data_ready_flag_q))
    else $error("channel read changed data ready");
  a_result_store:
    assert property (eoc_evt |-> s_store ##0 data_ready_flag_q
                     ##0 (chan_result[$past(core_chan)] == $past(core_data)))
    else $error("enabled result not stored or data ready not raised");
  a_eoc_read_clear:
    assert property (eoc_clr != '0 |=> (eoc_q & $past(eoc_clr) & ~$past(eoc_set)) == '0)
    else $error("done flag survived its clearing read");
  a_eoc_no_stray:
    assert property (1'b1 |=> ($past(eoc_q) & ~eoc_q & ~$past(eoc_clr)) == '0)
    else $error("done flag cleared without its own read");
  a_chan_overrun:
    assert property ((eoc_set & eoc_q) != '0 |=> (channel_overrun_flag_q & $past(channel_overrun_flag_set)) == $past(channel_overrun_flag_set))
    else $error("channel overrun not raised");
  a_gen_overrun:
    assert property (eoc_evt && data_ready_flag_q |=> general_overrun_flag_q [*1] ##0 data_ready_flag_q)
    else $error("general overrun not raised");
  a_sr_general_overrun_flag_clear:
    assert property (rd_sr && !general_overrun_flag_set |=> !general_overrun_flag_q)
    else $error("status read did not clear general overrun");
  a_sr_channel_overrun_flag_clear:
    assert property (rd_sr |=> (channel_overrun_flag_q & ~$past(eoc_q)) == '0)
    else $error("overrun of a channel without pending data survived");
  a_disabled_quiet:
    assert property (core_eoc && !chan_en_eff[core_chan] && !rd_last_result_reg
                     |=> $stable(last_data) && (data_ready_flag_q == $past(data_ready_flag_q))
                         && ((eoc_q & ~$past(eoc_q)) == '0))
    else $error("disabled channel produced data or flags");
  a_set_priority:
    assert property ((eoc_set & eoc_clr) != '0 |=> (eoc_q & $past(eoc_set)) == $past(eoc_set))
    else $error("completion lost to a same-cycle read");
  a_sleep_no_jump:
    assert property (wr_mode && !sleep_req |=> !conv_sleep ##1 !conv_sleep)
    else $error("sleep entered straight from the mode write");
  a_read_idle_zero:
    assert property (!rd_en |=> rd_data == `ARSF_RST_WORD)
    else $error("read data not zero outside a read answer");

endmodule

/* File: verification/arsf_core_model.sv */
// partner model: analog conversion core answering start pulses
`timescale 1ns/100ps

module arsf_core_model
#(
  parameter int                     CONV_CYC  = 4,
  parameter arsf_pkg::arsf_chan_t   CONV_CH   = 2'h0,
  parameter arsf_pkg::arsf_result_t CONV_DATA = 10'h2A5
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic                   conv_start,
  input  wire logic                   inj,
  input  wire arsf_pkg::arsf_chan_t   inj_chan,
  input  wire arsf_pkg::arsf_result_t inj_data,
  output logic                        core_eoc,
  output arsf_pkg::arsf_chan_t        core_chan,
  output arsf_pkg::arsf_result_t     core_data
);
  int                     cnt;
  logic                   fire;
  arsf_pkg::arsf_chan_t   last_chan;
  arsf_pkg::arsf_result_t last_data;

  // ------------------------------------------------------------
  // end of conversion
  // ------------------------------------------------------------
  // outside an eoc the lines toggle, so a design sampling them late sees junk
  assign fire      = (cnt == 1);
  assign core_eoc  = inj | fire;
  assign core_chan = inj ? inj_chan : (fire ? CONV_CH : ~last_chan);
  assign core_data = inj ? inj_data : (fire ? CONV_DATA : ~last_data);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt       <= 0;
      last_chan <= 2'h0;
      last_data <= 10'h000;
    end
    else
    begin
      if (conv_start)
        cnt <= CONV_CYC;
      else if (cnt != 0)
        cnt <= cnt - 1;
      last_chan <= core_chan;
      last_data <= core_data;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench of the converter result and status flag block
`timescale 1ns/100ps
`include "arsf_defines.svh"

module tb_top;
  logic                   sys_clk;
  logic                   arst_n;
  logic [`ARSF_AW-1:0]    addr;
  logic [`ARSF_BW-1:0]    wr_data;
  logic                   wr_en;
  logic                   rd_en;
  logic [`ARSF_BW-1:0]    rd_data;
  logic                   core_eoc;
  arsf_pkg::arsf_chan_t   core_chan;
  arsf_pkg::arsf_result_t core_data;
  logic                   conv_start;
  arsf_pkg::arsf_mask_t   chan_en;
  logic                   conv_sleep;
  logic                   inj;
  arsf_pkg::arsf_chan_t   inj_chan;
  arsf_pkg::arsf_result_t inj_data;
  logic [`ARSF_BW-1:0]    q;
  int                     error_cnt;
  int                     num_checks;
  int                     cycles;

  arsf_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .core_eoc(core_eoc),
    .core_chan(core_chan), .core_data(core_data), .conv_start(conv_start),
    .chan_en(chan_en), .conv_sleep(conv_sleep));

  arsf_core_model core (.sys_clk(sys_clk), .arst_n(arst_n), .conv_start(conv_start),
    .inj(inj), .inj_chan(inj_chan), .inj_data(inj_data), .core_eoc(core_eoc),
    .core_chan(core_chan), .core_data(core_data));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle, optionally with an end of conversion in the same cycle
  task automatic cyc(input logic r, input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic e, input logic [1:0] ch,
                     input logic [9:0] d);
    @(posedge sys_clk);
    rd_en    <= r;
    wr_en    <= w;
    addr     <= a;
    wr_data  <= wd;
    inj      <= e;
    inj_chan <= ch;
    inj_data <= d;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    inj   <= 1'b0;
    #1 q = rd_data;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1'b0, 1'b1, a, d, 1'b0, 2'h0, 10'h000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cyc(1'b1, 1'b0, a, 32'h0000_0000, 1'b0, 2'h0, 10'h000);
    chk(q, exp);
  endtask

  task automatic eoc(input logic [1:0] ch, input logic [9:0] d);
    cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b1, ch, d);
  endtask

  task automatic rde(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] ch, input logic [9:0] d);
    cyc(1'b1, 1'b0, a, 32'h0000_0000, 1'b1, ch, d);
    chk(q, exp);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk({31'h0, conv_sleep}, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wr(8'h08, 32'h0000_000F);
    rd(8'h10, 32'h0000_000F);
    $display("test reset done");
  endtask

  task automatic t_store;
    eoc(2'h2, 10'h155);
    rd(8'h14, 32'h0001_0004);
    rd(8'h28, 32'h0000_0155);
    rd(8'h14, 32'h0001_0000);
    rd(8'h18, 32'h0000_2155);
    rd(8'h14, 32'h0000_0000);
    eoc(2'h0, 10'h011);
    rde(8'h2C, 32'h0000_0000, 2'h1, 10'h022);
    rd(8'h14, 32'h0003_0003);
    rd(8'h18, 32'h0000_1022);
    rd(8'h20, 32'h0000_0011);
    rd(8'h14, 32'h0000_0000);
    $display("test store done");
  endtask

  task automatic t_overrun;
    eoc(2'h1, 10'h0AA);
    eoc(2'h1, 10'h0BB);
    rd(8'h14, 32'h0003_0202);
    rd(8'h24, 32'h0000_00BB);
    rde(8'h14, 32'h0001_0200, 2'h1, 10'h0CC);
    rd(8'h14, 32'h0003_0002);
    rd(8'h18, 32'h0000_10CC);
    eoc(2'h0, 10'h001);
    eoc(2'h0, 10'h002);
    rd(8'h20, 32'h0000_0002);
    rd(8'h18, 32'h0000_0002);
    rde(8'h14, 32'h0002_0100, 2'h3, 10'h333);
    rd(8'h14, 32'h0001_0008);
    rd(8'h18, 32'h0000_3333);
    rd(8'h14, 32'h0000_0000);
    $display("test overrun done");
  endtask

  task automatic t_disable;
    eoc(2'h0, 10'h010);
    cyc(1'b0, 1'b1, 8'h0C, 32'h0000_0008, 1'b1, 2'h0, 10'h020);
    chk({28'h0, chan_en}, 32'h0000_0007);
    rd(8'h14, 32'h0003_0101);
    rd(8'h20, 32'h0000_0020);
    rd(8'h18, 32'h0000_0020);
    rde(8'h24, 32'h0000_00CC, 2'h3, 10'h3FF);
    rd(8'h14, 32'h0000_0100);
    rd(8'h14, 32'h0000_0000);
    rd(8'h2C, 32'h0000_0333);
    rd(8'h18, 32'h0000_0020);
    rde(8'h20, 32'h0000_0020, 2'h0, 10'h030);
    rd(8'h14, 32'h0001_0001);
    rd(8'h18, 32'h0000_0030);
    rd(8'h14, 32'h0000_0000);
    $display("test disable done");
  endtask

  task automatic t_sleep;
    int n;
    wr(8'h04, 32'h0000_0001);
    repeat (5) @(posedge sys_clk);
    #1 chk({31'h0, conv_sleep}, 32'h0000_0000);
    rd(8'h04, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    chk({31'h0, conv_start}, 32'h0000_0001);
    n = 0;
    // the core answers within a few cycles; a bound keeps a dead design from hanging
    while (conv_sleep !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({31'h0, conv_sleep}, 32'h0000_0001);
    rd(8'h04, 32'h0000_0003);
    rd(8'h18, 32'h0000_02A5);
    rd(8'h14, 32'h0000_0000);
    wr(8'h04, 32'h0000_0000);
    // the request flop and the sleep state each take one edge
    @(posedge sys_clk);
    #1 chk({31'h0, conv_sleep}, 32'h0000_0000);
    $display("test sleep done");
  endtask

  // ------------------------------------------------------------
  // clock, reset, run
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    error_cnt  = 0;
    num_checks = 0;
    cycles     = 0;
    arst_n     = 1'b0;
    addr       = 8'h00;
    wr_data    = 32'h0000_0000;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    inj        = 1'b0;
    inj_chan   = 2'h0;
    inj_data   = 10'h000;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_store();
    t_overrun();
    t_disable();
    t_sleep();
    report_and_stop();
  end
endmodule
